// ### logic/irq_host_core.sv
module irq_host_core
    import irq_pkg::*;
(
    input wire logic clk,
    input wire logic srst,
    irq_link_if.host link,
    input wire logic [2:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    output logic irq
);
    host_state_type state_reg;
    logic rd_reg;
    logic wr_reg;
    logic inta_reg;
    logic [7:0] addr_reg;
    logic [7:0] wdata_reg;
    logic [7:0] io_result_reg;
    logic [7:0] vector_reg;
    logic auto_reg;
    logic [7:0] io_addr_cfg_reg;
    logic [7:0] io_wdata_cfg_reg;
    logic [ST_W-1:0] status_reg;
    logic [ST_W-1:0] status_set;
    logic [ST_W-1:0] irq_mask_reg;
    logic wait_reg;
    logic irq_reg;
    logic [31:0] readdata_reg;
    logic bus_wr;
    logic start_sw;
    logic start_auto;
    logic [TABLE_ADDR_W-1:0] table_addr;

    assign link.io_read = rd_reg;
    assign link.io_write = wr_reg;
    assign link.io_inta = inta_reg;
    assign link.io_addr = addr_reg;
    assign link.io_wdata = wdata_reg;
    assign avs_waitrequest = wait_reg;
    assign avs_readdata = readdata_reg;
    assign irq = irq_reg;

    assign bus_wr = avs_write && !wait_reg;
    assign start_sw = bus_wr && avs_address == REG_COMMAND && state_reg == HOST_IDLE
        && (avs_writedata[CMD_WRITE_BIT] || avs_writedata[CMD_READ_BIT]);
    assign start_auto = !start_sw && state_reg == HOST_IDLE && auto_reg && link.int_request;
    assign table_addr = TABLE_ADDR_W'({vector_reg, {ENTRY_SHIFT{1'b0}}});

    // One wait cycle: the slave releases waitrequest for exactly one edge.
    always_ff @(posedge clk) begin
        if (srst) begin
            wait_reg <= 1'b1;
        end else begin
            wait_reg <= !((avs_read || avs_write) && wait_reg);
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            readdata_reg <= '0;
        end else if (avs_read && wait_reg) begin
            readdata_reg <= '0;
            case (avs_address)
                REG_COMMAND: begin
                    readdata_reg[CMD_AUTO_BIT] <= auto_reg;
                end
                REG_IO: begin
                    readdata_reg[15:0] <= {io_wdata_cfg_reg, io_addr_cfg_reg};
                end
                REG_RESULT: begin
                    readdata_reg[7:0] <= io_result_reg;
                    readdata_reg[15:8] <= vector_reg;
                    readdata_reg[16+TABLE_ADDR_W-1:16] <= table_addr;
                    readdata_reg[RES_BUSY_BIT] <= state_reg != HOST_IDLE;
                end
                REG_STATUS: begin
                    readdata_reg[ST_W-1:0] <= status_reg;
                end
                REG_IRQ_MASK: begin
                    readdata_reg[ST_W-1:0] <= irq_mask_reg;
                end
                default: begin
                    readdata_reg <= '0;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            auto_reg <= 1'b0;
            io_addr_cfg_reg <= '0;
            io_wdata_cfg_reg <= '0;
            irq_mask_reg <= '0;
        end else if (bus_wr) begin
            if (avs_address == REG_COMMAND) begin
                auto_reg <= avs_writedata[CMD_AUTO_BIT];
            end
            if (avs_address == REG_IO) begin
                io_addr_cfg_reg <= avs_writedata[7:0];
                io_wdata_cfg_reg <= avs_writedata[15:8];
            end
            if (avs_address == REG_IRQ_MASK) begin
                irq_mask_reg <= avs_writedata[ST_W-1:0];
            end
        end
    end

    // Link sequencer: request held until the device acknowledges.
    always_ff @(posedge clk) begin
        if (srst) begin
            state_reg <= HOST_IDLE;
            rd_reg <= 1'b0;
            wr_reg <= 1'b0;
            inta_reg <= 1'b0;
            addr_reg <= '0;
            wdata_reg <= '0;
        end else begin
            case (state_reg)
                HOST_IDLE: begin
                    if (start_sw) begin
                        wr_reg <= avs_writedata[CMD_WRITE_BIT];
                        rd_reg <= !avs_writedata[CMD_WRITE_BIT];
                        addr_reg <= io_addr_cfg_reg;
                        wdata_reg <= io_wdata_cfg_reg;
                        state_reg <= HOST_WAIT;
                    end else if (start_auto) begin
                        inta_reg <= 1'b1;
                        state_reg <= HOST_WAIT;
                    end
                end
                HOST_WAIT: begin
                    if (link.io_ack) begin
                        rd_reg <= 1'b0;
                        wr_reg <= 1'b0;
                        inta_reg <= 1'b0;
                        state_reg <= HOST_IDLE;
                    end
                end
                default: begin
                    state_reg <= HOST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            io_result_reg <= '0;
            vector_reg <= '0;
        end else if (state_reg == HOST_WAIT && link.io_ack) begin
            if (inta_reg) begin
                vector_reg <= link.io_rdata;
            end else if (rd_reg) begin
                io_result_reg <= link.io_rdata;
            end
        end
    end

    always_comb begin
        status_set = '0;
        if (state_reg == HOST_WAIT && link.io_ack) begin
            status_set[ST_OP_DONE_BIT] = !inta_reg;
            status_set[ST_VECTOR_BIT] = inta_reg;
        end
    end

    // Write one to clear; a new event in the same cycle wins.
    always_ff @(posedge clk) begin
        if (srst) begin
            status_reg <= '0;
        end else if (bus_wr && avs_address == REG_STATUS) begin
            status_reg <= (status_reg & ~avs_writedata[ST_W-1:0]) | status_set;
        end else begin
            status_reg <= status_reg | status_set;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            irq_reg <= 1'b0;
        end else begin
            irq_reg <= |(status_reg & irq_mask_reg);
        end
    end
endmodule: irq_host_core

// ### logic/irq_link_if.sv
interface irq_link_if;
    logic io_read;
    logic io_write;
    logic io_inta;
    logic [7:0] io_addr;
    logic [7:0] io_wdata;
    logic [7:0] io_rdata;
    logic io_ack;
    logic int_request;

    modport device (
        input io_read,
        input io_write,
        input io_inta,
        input io_addr,
        input io_wdata,
        output io_rdata,
        output io_ack,
        output int_request
    );

    modport host (
        output io_read,
        output io_write,
        output io_inta,
        output io_addr,
        output io_wdata,
        input io_rdata,
        input io_ack,
        input int_request
    );
endinterface: irq_link_if

// ### logic/irq_pkg.sv
// How it works
// - ISA-side lines latch a request on rising edge.
// - PCI-side lines request while the level stays high.
// - Line 0 ranks highest, line 7 lowest.
// - Higher priority preempts service; lower waits.
// - Interrupt only for unmasked lines winning arbitration.
// - Mask bit n governs request line n.
// - Mask one blocks a line, zero allows it.
// - Mask register read and written at port 21h.
// - Controller supplies an 8-bit vector after interrupting.
// - Processor indexes vector table in lowest 1024 bytes.
// - Software clears source flag, then sends done command.
// - Peripherals space requests at least 125 ns apart.
// - Fifteen usable lines from two cascaded eight-line banks.
// - Software checks every source sharing one line.
package irq_pkg;
    localparam int NUM_LINES = 16;
    localparam int LINE_W = 4;
    localparam int BANK_LINES = 8;
    localparam logic [7:0] PORT_CMD_MASTER = 8'h20;
    localparam logic [7:0] PORT_MASK_MASTER = 8'h21;
    localparam logic [7:0] PORT_CMD_SLAVE = 8'ha0;
    localparam logic [7:0] PORT_MASK_SLAVE = 8'ha1;
    localparam logic [7:0] SERVICE_DONE_COMMAND = 8'h20;
    localparam logic [7:0] MASK_RESET = 8'hff;
    localparam logic [7:0] VECTOR_BASE_MASTER = 8'h08;
    localparam logic [7:0] VECTOR_BASE_SLAVE = 8'h70;
    localparam logic [2:0] SPURIOUS_LINE = 3'h7;
    localparam logic [3:0] CASCADE_LINE = 4'h2;
    localparam logic [4:0] RANK_NONE = 5'h10;
    localparam int TABLE_ADDR_W = 10;
    localparam int ENTRY_SHIFT = 2;
    localparam int REQ_SPACING_NS = 125;
    // Host-side register map, word indices on the Avalon-MM port.
    localparam logic [2:0] REG_COMMAND = 3'h0;
    localparam logic [2:0] REG_IO = 3'h1;
    localparam logic [2:0] REG_RESULT = 3'h2;
    localparam logic [2:0] REG_STATUS = 3'h3;
    localparam logic [2:0] REG_IRQ_MASK = 3'h4;
    localparam int CMD_WRITE_BIT = 0;
    localparam int CMD_READ_BIT = 1;
    localparam int CMD_AUTO_BIT = 2;
    localparam int ST_OP_DONE_BIT = 0;
    localparam int ST_VECTOR_BIT = 1;
    localparam int ST_W = 2;
    localparam int RES_BUSY_BIT = 31;

    typedef enum logic [1:0] {
        HOST_IDLE = 2'b00,
        HOST_WAIT = 2'b01
    } host_state_type;

    // Cascade on line 2: order is 0, 1, 8..15, 3..7; line 2 itself never wins.
    function automatic logic [4:0] line_rank(input logic [3:0] idx);
        logic [4:0] r;
        r = {1'b0, idx};
        if (idx >= 4'h8) begin
            r = 5'(idx - 4'h6);
        end else if (idx == CASCADE_LINE) begin
            r = 5'h0f;
        end else if (idx > CASCADE_LINE) begin
            r = 5'(idx + 4'h7);
        end
        return r;
    endfunction: line_rank
endpackage: irq_pkg

// ### logic/priority_request_controller.sv
module priority_request_controller
    import irq_pkg::*;
#(
    parameter logic [NUM_LINES-1:0] LEVEL_LINES = 16'h0c00
) (
    input wire logic clk,
    input wire logic srst,
    irq_link_if.device link,
    input wire logic [NUM_LINES-1:0] request_line_n
);
    logic [NUM_LINES-1:0] sync1_reg;
    logic [NUM_LINES-1:0] sync2_reg;
    logic [NUM_LINES-1:0] sync3_reg;
    logic [NUM_LINES-1:0] level_reg;
    logic [NUM_LINES-1:0] level_next;
    logic [NUM_LINES-1:0] pending_reg;
    logic [NUM_LINES-1:0] inservice_reg;
    logic [NUM_LINES-1:0] mask_reg;
    logic [NUM_LINES-1:0] requests;
    logic [NUM_LINES-1:0] eligible;
    logic [NUM_LINES-1:0] grant_clear;
    logic [NUM_LINES-1:0] done_clear;
    logic [4:0] best_rank;
    logic [3:0] best_idx;
    logic [4:0] svc_rank;
    logic [4:0] master_done_rank;
    logic [4:0] slave_done_rank;
    logic [3:0] master_done_idx;
    logic [3:0] slave_done_idx;
    logic win;
    logic take;
    logic ack_reg;
    logic int_reg;
    logic [7:0] rdata_reg;

    assign link.io_ack = ack_reg;
    assign link.int_request = int_reg;
    assign link.io_rdata = rdata_reg;
    assign take = (link.io_read || link.io_write || link.io_inta) && !ack_reg;

    // Three-stage synchroniser; a level counts once stages two and three agree.
    always_ff @(posedge clk) begin
        if (srst) begin
            sync1_reg <= '0;
            sync2_reg <= '0;
            sync3_reg <= '0;
            level_reg <= '0;
        end else begin
            sync1_reg <= request_line_n;
            sync2_reg <= sync1_reg;
            sync3_reg <= sync2_reg;
            level_reg <= level_next;
        end
    end

    assign level_next = (sync2_reg & sync3_reg) | (level_reg & (sync2_reg | sync3_reg));

    // Edge lines latch a request; a rise in the grant cycle is kept.
    always_ff @(posedge clk) begin
        if (srst) begin
            pending_reg <= '0;
        end else begin
            pending_reg <= (pending_reg & ~grant_clear) | (level_next & ~level_reg);
        end
    end

    always_comb begin
        requests = (pending_reg & ~LEVEL_LINES) | (level_reg & LEVEL_LINES);
        eligible = requests & ~mask_reg & ~inservice_reg;
        if (mask_reg[CASCADE_LINE]) begin
            eligible[NUM_LINES-1:BANK_LINES] = '0;
        end
        eligible[CASCADE_LINE] = 1'b0;
    end

    // Arbitration by rank, against the best line now in service.
    always_comb begin
        best_rank = RANK_NONE;
        best_idx = '0;
        svc_rank = RANK_NONE;
        master_done_rank = RANK_NONE;
        slave_done_rank = RANK_NONE;
        master_done_idx = '0;
        slave_done_idx = '0;
        for (int i = 0; i < NUM_LINES; i++) begin
            if (eligible[i] && line_rank(LINE_W'(i)) < best_rank) begin
                best_rank = line_rank(LINE_W'(i));
                best_idx = LINE_W'(i);
            end
            if (inservice_reg[i] && line_rank(LINE_W'(i)) < svc_rank) begin
                svc_rank = line_rank(LINE_W'(i));
            end
            if (inservice_reg[i] && i < BANK_LINES
                && line_rank(LINE_W'(i)) < master_done_rank) begin
                master_done_rank = line_rank(LINE_W'(i));
                master_done_idx = LINE_W'(i);
            end
            if (inservice_reg[i] && i >= BANK_LINES
                && line_rank(LINE_W'(i)) < slave_done_rank) begin
                slave_done_rank = line_rank(LINE_W'(i));
                slave_done_idx = LINE_W'(i);
            end
        end
        win = best_rank < svc_rank;
    end

    always_comb begin
        grant_clear = '0;
        done_clear = '0;
        if (take && link.io_inta && win) begin
            grant_clear[best_idx] = 1'b1;
        end
        if (take && link.io_write && link.io_wdata == SERVICE_DONE_COMMAND) begin
            if (link.io_addr == PORT_CMD_MASTER && master_done_rank != RANK_NONE) begin
                done_clear[master_done_idx] = 1'b1;
            end
            if (link.io_addr == PORT_CMD_SLAVE && slave_done_rank != RANK_NONE) begin
                done_clear[slave_done_idx] = 1'b1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            inservice_reg <= '0;
        end else begin
            inservice_reg <= (inservice_reg & ~done_clear) | grant_clear;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            mask_reg <= {MASK_RESET, MASK_RESET};
        end else if (take && link.io_write) begin
            if (link.io_addr == PORT_MASK_MASTER) begin
                mask_reg[BANK_LINES-1:0] <= link.io_wdata;
            end
            if (link.io_addr == PORT_MASK_SLAVE) begin
                mask_reg[NUM_LINES-1:BANK_LINES] <= link.io_wdata;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            int_reg <= 1'b0;
        end else begin
            int_reg <= win && !grant_clear[best_idx];
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            ack_reg <= 1'b0;
        end else begin
            ack_reg <= take;
        end
    end

    // A vector fetch with no winner returns the master's spurious vector.
    always_ff @(posedge clk) begin
        if (srst) begin
            rdata_reg <= '0;
        end else if (take) begin
            rdata_reg <= '0;
            if (link.io_inta) begin
                if (!win) begin
                    rdata_reg <= VECTOR_BASE_MASTER + {5'h00, SPURIOUS_LINE};
                end else if (best_idx >= LINE_W'(BANK_LINES)) begin
                    rdata_reg <= VECTOR_BASE_SLAVE + {5'h00, best_idx[2:0]};
                end else begin
                    rdata_reg <= VECTOR_BASE_MASTER + {5'h00, best_idx[2:0]};
                end
            end else if (link.io_read && link.io_addr == PORT_MASK_MASTER) begin
                rdata_reg <= mask_reg[BANK_LINES-1:0];
            end else if (link.io_read && link.io_addr == PORT_MASK_SLAVE) begin
                rdata_reg <= mask_reg[NUM_LINES-1:BANK_LINES];
            end
        end
    end
endmodule: priority_request_controller

// ### verif/irq_link_asserts.sv
module irq_link_checker
    import irq_pkg::*;
(
    input wire logic clk,
    input wire logic srst,
    input wire logic io_read,
    input wire logic io_write,
    input wire logic io_inta,
    input wire logic [7:0] io_addr,
    input wire logic [7:0] io_wdata,
    input wire logic [7:0] io_rdata,
    input wire logic io_ack,
    input wire logic int_request
);
    logic taken;
    logic [7:0] shadow_master_reg;
    logic [7:0] shadow_slave_reg;
    logic opened_reg;
    logic [1:0] sealed_reg;

    assign taken = (io_read | io_write | io_inta) & ~io_ack;

    // Shadow copies of both mask bytes, as last written across the link.
    always_ff @(posedge clk) begin
        if (srst) begin
            shadow_master_reg <= MASK_RESET;
            shadow_slave_reg <= MASK_RESET;
        end else if (io_ack && io_write && io_addr == PORT_MASK_MASTER) begin
            shadow_master_reg <= io_wdata;
        end else if (io_ack && io_write && io_addr == PORT_MASK_SLAVE) begin
            shadow_slave_reg <= io_wdata;
        end
    end

    // Set once any mask byte has been written with at least one clear bit.
    always_ff @(posedge clk) begin
        if (srst) begin
            opened_reg <= 1'b0;
        end else if (io_ack && io_write && io_wdata != 8'hff
                && (io_addr == PORT_MASK_MASTER || io_addr == PORT_MASK_SLAVE)) begin
            opened_reg <= 1'b1;
        end
    end

    // Counts cycles with every master line masked, saturating at three.
    always_ff @(posedge clk) begin
        if (srst || shadow_master_reg != 8'hff) begin
            sealed_reg <= 2'h0;
        end else if (sealed_reg != 2'h3) begin
            sealed_reg <= sealed_reg + 2'h1;
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (srst);

    property p_ack_follows; taken |=> io_ack; endproperty
    a_ack_follows: assert property (p_ack_follows)
        else $error("request not answered on the next cycle");
    property p_ack_pulse; io_ack |=> !io_ack; endproperty
    a_ack_pulse: assert property (p_ack_pulse)
        else $error("acknowledge longer than one cycle");
    property p_ack_cause; io_ack |-> $past(taken); endproperty
    a_ack_cause: assert property (p_ack_cause)
        else $error("acknowledge without a request");
    property p_req_held; taken |=> $stable({io_read, io_write, io_inta, io_addr, io_wdata});
    endproperty
    a_req_held: assert property (p_req_held)
        else $error("request changed before its answer");
    property p_one_strobe; $onehot0({io_read, io_write, io_inta}); endproperty
    a_one_strobe: assert property (p_one_strobe)
        else $error("two request strobes at once");
    property p_rdata_holds; !io_ack |-> $stable(io_rdata); endproperty
    a_rdata_holds: assert property (p_rdata_holds)
        else $error("read data changed without an answer");
    property p_mask_readback;
        io_ack && io_read && (io_addr == PORT_MASK_MASTER || io_addr == PORT_MASK_SLAVE)
            |-> io_rdata == (io_addr == PORT_MASK_MASTER ? shadow_master_reg : shadow_slave_reg);
    endproperty
    a_mask_readback: assert property (p_mask_readback)
        else $error("mask read back differs from mask written");
    property p_vector_legal;
        io_inta && io_ack |-> io_rdata inside {[8'h08:8'h09], [8'h0b:8'h0f], [8'h70:8'h77]};
    endproperty
    a_vector_legal: assert property (p_vector_legal)
        else $error("vector outside the serviceable lines");
    property p_masked_quiet; !opened_reg |-> !int_request; endproperty
    a_masked_quiet: assert property (p_masked_quiet)
        else $error("interrupt while every line is masked");
    property p_sealed; sealed_reg == 2'h3 |-> !int_request; endproperty
    a_sealed: assert property (p_sealed)
        else $error("interrupt while the master bank is fully masked");

    c_vector: cover property (io_inta && io_ack);
    c_done_slave: cover property (io_ack && io_write && io_addr == PORT_CMD_SLAVE);
    c_slave_read: cover property (io_ack && io_read && io_addr == PORT_MASK_SLAVE);
    c_int_rise: cover property ($rose(int_request));
endmodule: irq_link_checker

// ### verif/tb_prioritized_interrupt_controller.sv
module tb_prioritized_interrupt_controller
    import irq_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    logic clk = 1'b0;
    logic srst = 1'b1;
    logic [2:0] avs_address = 3'h0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic irq;
    logic [NUM_LINES-1:0] request_line_n = 16'h0000;
    logic auto_on = 1'b0;
    int mismatches = 0;
    int n_compared = 0;

    irq_link_if link ();
    priority_request_controller priority_request_controller_inst (.clk(clk), .srst(srst),
        .link(link.device), .request_line_n(request_line_n));
    irq_host_core irq_host_core_inst (.clk(clk), .srst(srst), .link(link.host),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .irq(irq));
    irq_link_checker irq_link_checker_inst (.clk(clk), .srst(srst), .io_read(link.io_read),
        .io_write(link.io_write), .io_inta(link.io_inta), .io_addr(link.io_addr),
        .io_wdata(link.io_wdata), .io_rdata(link.io_rdata), .io_ack(link.io_ack),
        .int_request(link.int_request));

    always #2.5 clk = ~clk;

    function automatic logic [7:0] vec_of(input int l);
        return l < 8 ? VECTOR_BASE_MASTER + 8'(l) : VECTOR_BASE_SLAVE + 8'(l - 8);
    endfunction: vec_of

    function automatic int rank_of(input int l);
        return l < 2 ? l : (l >= 8 ? l - 6 : l + 7);
    endfunction: rank_of

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            mismatches++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask: check

    task automatic summarize();
        $display("compared %0d, mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask: summarize

    // One Avalon transfer; the request stands until waitrequest is sampled low.
    task automatic avs_xfer(input logic rd, input logic [2:0] a, input logic [31:0] d,
            output logic [31:0] q);
        int n;
        @(posedge clk);
        avs_address <= a;
        avs_read <= rd;
        avs_write <= ~rd;
        avs_writedata <= d;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 50);
        q = avs_readdata;
        check(avs_waitrequest, 32'h0);
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask: avs_xfer

    task automatic wr(input logic [2:0] a, input logic [31:0] d);
        logic [31:0] q;
        avs_xfer(1'b0, a, d, q);
    endtask: wr

    task automatic link_op(input logic rd, input logic [7:0] port, input logic [7:0] d,
            output logic [7:0] q);
        logic [31:0] s;
        int n;
        wr(REG_IO, {16'h0000, d, port});
        wr(REG_COMMAND, {29'h0, auto_on, rd, ~rd});
        n = 0;
        do begin
            avs_xfer(1'b1, REG_STATUS, 32'h0, s);
            n++;
        end while (s[ST_OP_DONE_BIT] !== 1'b1 && n < 40);
        check(s[ST_OP_DONE_BIT], 32'h1);
        avs_xfer(1'b1, REG_RESULT, 32'h0, s);
        q = s[7:0];
        wr(REG_STATUS, 32'h1);
    endtask: link_op

    task automatic mask_set(input logic [7:0] port, input logic [7:0] d);
        logic [7:0] q;
        link_op(1'b0, port, d, q);
    endtask: mask_set

    task automatic done_cmd(input int line);
        logic [7:0] q;
        link_op(1'b0, line >= 8 ? PORT_CMD_SLAVE : PORT_CMD_MASTER, SERVICE_DONE_COMMAND, q);
    endtask: done_cmd

    // Peripherals keep the minimum request spacing, in 5 ns cycles, between line changes.
    task automatic lines(input logic [15:0] v);
        repeat (REQ_SPACING_NS / 5) @(posedge clk);
        request_line_n <= v;
    endtask: lines

    task automatic quiet();
        repeat (30) @(posedge clk);
        check(irq, 32'h0);
        check(link.int_request, 32'h0);
    endtask: quiet

    task automatic expect_vector(input int line);
        logic [31:0] s;
        int n;
        n = 0;
        while (irq !== 1'b1 && n < 200) begin
            @(posedge clk);
            n++;
        end
        check(irq, 32'h1);
        avs_xfer(1'b1, REG_STATUS, 32'h0, s);
        check(s[ST_VECTOR_BIT], 32'h1);
        avs_xfer(1'b1, REG_RESULT, 32'h0, s);
        check(s[15:8], vec_of(line));
        check(s[25:16], {vec_of(line), 2'b00});
        check(s[RES_BUSY_BIT], 32'h0);
        wr(REG_STATUS, 32'h3);
    endtask: expect_vector

    initial begin
        repeat (40000) @(posedge clk);
        mismatches++;
        summarize();
    end

    initial begin
        logic [7:0] b;
        logic [7:0] v;
        logic [31:0] s;
        logic [15:0] pend;
        int best;
        s = $urandom(24621);
        repeat (12) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        link_op(1'b1, PORT_MASK_MASTER, 8'h00, b);
        check(b, MASK_RESET);
        link_op(1'b1, PORT_MASK_SLAVE, 8'h00, b);
        check(b, MASK_RESET);
        for (int i = 0; i < 6; i++) begin
            v = 8'($urandom);
            mask_set(i[0] ? PORT_MASK_SLAVE : PORT_MASK_MASTER, v);
            link_op(1'b1, i[0] ? PORT_MASK_SLAVE : PORT_MASK_MASTER, 8'h00, b);
            check(b, v);
        end
        mask_set(8'h55, 8'h3c);
        link_op(1'b1, 8'h55, 8'h00, b);
        check(b, 8'h00);
        wr(3'h5, $urandom);
        avs_xfer(1'b1, 3'h5, 32'h0, s);
        check(s, 32'h0);
        auto_on = 1'b1;
        wr(REG_COMMAND, 32'h4);
        wr(REG_IRQ_MASK, 32'h2);
        avs_xfer(1'b1, REG_IRQ_MASK, 32'h0, s);
        check(s, 32'h2);
        avs_xfer(1'b1, REG_COMMAND, 32'h0, s);
        check(s, 32'h4);
        // A masked line stays silent; the host irq mask gates the fetched vector.
        mask_set(PORT_MASK_SLAVE, 8'hff);
        mask_set(PORT_MASK_MASTER, 8'h10);
        lines(16'h0010);
        quiet();
        wr(REG_IRQ_MASK, 32'h0);
        mask_set(PORT_MASK_MASTER, 8'h00);
        repeat (30) @(posedge clk);
        check(irq, 32'h0);
        avs_xfer(1'b1, REG_STATUS, 32'h0, s);
        check(s[ST_VECTOR_BIT], 32'h1);
        wr(REG_IRQ_MASK, 32'h2);
        expect_vector(4);
        done_cmd(4);
        lines(16'h0000);
        mask_set(PORT_MASK_SLAVE, 8'h00);
        // Random groups of edge lines are served strictly by rank.
        repeat (3) begin
            pend = 16'($urandom) & 16'hf3fb | 16'h0100;
            lines(pend);
            while (pend != 16'h0000) begin
                best = 16;
                for (int l = 0; l < 16; l++)
                    if (pend[l] && (best == 16 || rank_of(l) < rank_of(best))) best = l;
                expect_vector(best);
                pend[best] = 1'b0;
                done_cmd(best);
            end
            quiet();
            lines(16'h0000);
        end
        lines(16'h0020);
        expect_vector(5);
        lines(16'h0028);
        expect_vector(3);
        lines(16'h00a8);
        quiet();
        done_cmd(3);
        quiet();
        done_cmd(5);
        expect_vector(7);
        done_cmd(7);
        lines(16'h0000);
        lines(16'h0400);
        expect_vector(10);
        done_cmd(10);
        expect_vector(10);
        lines(16'h0000);
        done_cmd(10);
        quiet();
        summarize();
    end
endmodule: tb_prioritized_interrupt_controller
